/* File: verilog/vtms_top.sv */
/*
  Velocity threshold mode selector: compares step interval and ramp
  velocity against thresholds and drives the chopper feature enables.
  Assumes synchronous inputs, a plain register port and one clock.
*/
// Behaviour
// - Slow interval allows PWM, blocks commutation
// - Hold 20-bit low velocity threshold
// - Middle band: scaling on, PWM off
// - Stall stop/output armed below low interval
// - Blank stall detection after high crossings
// - High band: scaling off, PWM off
// - High band chopper flag forces slow decay
// - High band switches synchronisation off
// - High band fullstep flag: fullstep, commutation detector
// - 23-bit commutation threshold, ramp source only
// - Step/dir mode: commutation from enable input
// - Zero threshold disables automatic commutation
// - Velocity above threshold acts as high band
// - Only threshold bits 22..8 used
// - Commutation writes back actual position
// - Commutation threshold is minimum step velocity
// - Interval counts clocks, saturates all ones
// - Comparisons use 1/16 or 1/32 hysteresis
`timescale 1ns/100ps
module vtms_top
  import vtms_pkg::*;
(
  input  wire  logic                sys_clk,
  input  wire  logic                reset,
  input  wire  logic [7:0]          reg_addr,
  input  wire  logic [31:0]         reg_wdata,
  input  wire  logic                reg_wr,
  input  wire  logic                reg_rd,
  output logic       [31:0]         reg_rdata,
  input  wire  logic                step_pulse,
  input  wire  logic                ramp_mode,
  input  wire  logic signed [23:0]  actual_velocity,
  input  wire  logic                commutation_enable_input,
  input  wire  logic                comm_step,
  input  wire  logic                comm_dir,
  input  wire  logic [31:0]         actual_position,
  output logic                      voltage_pwm_en,
  output logic                      coolscale_en,
  output logic                      stall_stop_en,
  output logic                      stall_out_en,
  output logic                      stall_suppress,
  output logic                      chopper_mode_force,
  output logic                      sync_off,
  output logic                      fullstep_en,
  output logic                      stall_det_comm,
  output logic                      commutation_en,
  output logic                      min_velocity_active,
  output logic       [22:0]         min_velocity,
  output logic                      position_wr,
  output logic       [31:0]         position_wr_data
);

  ////////////////////////////////////////////////////////////////////
  // State

  // Whole state of the selector
  typedef struct packed {
    logic [19:0]       thr_pwm;   // Voltage PWM threshold
    logic [19:0]       thr_low;   // Low velocity threshold
    logic [19:0]       thr_high;  // High velocity threshold
    logic [14:0]       comm_thr;  // Commutation threshold bits 22..8
    logic [CFG_W-1:0]  cfg;       // Feature configuration
    logic [31:0]       rdata;     // Read data, one cycle
    logic              high_mode; // High band active
    logic              stall_arm; // Stall functions armed
    logic [SUPP_W-1:0] supp_cnt;  // Microsteps left to blank
    logic              pwm_en;    // Registered enables
    logic              cool_en;
    logic              stop_en;
    logic              sout_en;
    logic              supp;
    logic              chm_force;
    logic              sync_off;
    logic              fs_en;
    logic              det_comm;
    logic              comm_en;
    logic              minv_act;
    logic              pos_wr;    // Position write pulse
    logic [31:0]       pos_data;  // Position write value
  } vtms_state_t;

  vtms_state_t st_ff;   // Registered state
  vtms_state_t nxt_st;  // Next state

  vtms_meas_if mif ();  // Link to interval measurement

  logic [23:0] vel_mag;   // Magnitude of actual velocity
  logic [23:0] comm_full; // Threshold with low bits zero
  logic        comm_vel;  // Velocity above commutation threshold
  logic        high;      // High band this cycle
  logic        comm_raw;  // Commutation request
  logic        comm;      // Commutation granted
  logic [31:0] status;    // Status word

  ////////////////////////////////////////////////////////////////////
  // Interval measurement

  // Feed thresholds and microsteps to the comparators
  assign mif.step_evt  = step_pulse;
  assign mif.small_hys = st_ff.cfg[CFG_SMALL_HYS];
  assign mif.thr_pwm   = st_ff.thr_pwm;
  assign mif.thr_low   = st_ff.thr_low;
  assign mif.thr_high  = st_ff.thr_high;

  vtms_interval u_interval (
    .sys_clk (sys_clk),
    .reset   (reset),
    .mif     (mif)
  );

  ////////////////////////////////////////////////////////////////////
  // Velocity decisions

  // Magnitude and commutation comparison
  always_comb begin
    // Absolute velocity
    vel_mag   = actual_velocity[23] ? 24'(-actual_velocity)
                                    : 24'(actual_velocity);
    // Low bits ignored in the compare
    comm_full = {1'b0, st_ff.comm_thr, COMM_PAD};
    // Ramp source only, zero or small disables
    comm_vel  = ramp_mode && (comm_full >= COMM_MIN)
                && (vel_mag >= comm_full);
    // Interval band or commutation velocity
    high      = mif.fast_high | comm_vel;
    // Step/dir mode uses the enable input alone
    comm_raw  = ramp_mode ? comm_vel
                          : commutation_enable_input;
    // Slow interval keeps commutation off
    comm      = comm_raw & mif.fast_pwm;
  end

  // Status word for software
  always_comb begin
    status    = RD_ZERO;
    status[0] = st_ff.pwm_en;
    status[1] = st_ff.cool_en;
    status[2] = st_ff.stall_arm;
    status[3] = st_ff.high_mode;
    status[4] = st_ff.comm_en;
    status[5] = st_ff.supp;
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = st_ff;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_PWM_THR: begin
          nxt_st.thr_pwm = reg_wdata[19:0];
        end
        ADDR_LOW_THR: begin
          nxt_st.thr_low = reg_wdata[19:0];
        end
        ADDR_HIGH_THR: begin
          nxt_st.thr_high = reg_wdata[19:0];
        end
        ADDR_COMM_THR: begin
          // Only upper bits are kept
          nxt_st.comm_thr = reg_wdata[COMM_HI:COMM_LO];
        end
        ADDR_CONFIG: begin
          nxt_st.cfg = reg_wdata[CFG_W-1:0];
        end
        default: begin
          // Unmapped writes ignored
        end
      endcase
    end

    // Read data stands one cycle only
    nxt_st.rdata = RD_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CONFIG: begin
          nxt_st.rdata = {25'h0000000, st_ff.cfg};
        end
        ADDR_STATUS: begin
          nxt_st.rdata = status;
        end
        ADDR_INTERVAL: begin
          nxt_st.rdata = {12'h000, mif.interval};
        end
        default: begin
          // Thresholds write only, unmapped read zero
          nxt_st.rdata = RD_ZERO;
        end
      endcase
    end

    // Band tracking
    nxt_st.high_mode = high;

    // Blank stall detection after each high crossing
    if (high != st_ff.high_mode) begin
      nxt_st.supp_cnt = SUPP_COUNT;
    end else if (step_pulse && (st_ff.supp_cnt != SUPP_ZERO)) begin
      nxt_st.supp_cnt = st_ff.supp_cnt - SUPP_ONE;
    end
    nxt_st.supp = (nxt_st.supp_cnt != SUPP_ZERO);

    // Arm stall functions below low interval
    if (mif.fast_low) begin
      nxt_st.stall_arm = 1'b1;
    end else if (!comm) begin
      // Outside commutation, slow speed disarms
      nxt_st.stall_arm = 1'b0;
    end

    // Voltage PWM only in slow band
    nxt_st.pwm_en  = st_ff.cfg[CFG_PWM] & ~mif.fast_low
                     & ~high;
    // Load scaling between low and high
    nxt_st.cool_en = st_ff.cfg[CFG_COOL] & mif.fast_low
                     & ~high;
    // Stop on stall with internal motion controller
    nxt_st.stop_en = st_ff.cfg[CFG_STOP] & ramp_mode
                     & nxt_st.stall_arm & ~nxt_st.supp;
    // Stall output
    nxt_st.sout_en = st_ff.cfg[CFG_STALL_OUT]
                     & nxt_st.stall_arm & ~nxt_st.supp;

    // High band chopper overrides
    nxt_st.chm_force = high & st_ff.cfg[CFG_HIGH_CHM];
    nxt_st.sync_off  = high;
    nxt_st.fs_en     = high & st_ff.cfg[CFG_HIGH_FS];
    nxt_st.det_comm  = (high & st_ff.cfg[CFG_HIGH_FS]) | comm;

    // Commutation and its minimum velocity
    nxt_st.comm_en  = comm;
    nxt_st.minv_act = comm & ramp_mode;

    // Position follows the commutation
    nxt_st.pos_wr = comm & comm_step;
    if (comm && comm_step) begin
      nxt_st.pos_data = comm_dir ? (actual_position - POS_STEP)
                                 : (actual_position + POS_STEP);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      // All thresholds and enables clear
      st_ff <= '{thr_pwm: THR_RESET, thr_low: THR_RESET,
                 thr_high: THR_RESET, comm_thr: COMM_RESET,
                 cfg: CFG_RESET, rdata: RD_ZERO,
                 supp_cnt: SUPP_ZERO, pos_data: RD_ZERO,
                 default: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  // All outputs from flops
  assign reg_rdata           = st_ff.rdata;
  assign voltage_pwm_en      = st_ff.pwm_en;
  assign coolscale_en        = st_ff.cool_en;
  assign stall_stop_en       = st_ff.stop_en;
  assign stall_out_en        = st_ff.sout_en;
  assign stall_suppress      = st_ff.supp;
  assign chopper_mode_force  = st_ff.chm_force;
  assign sync_off            = st_ff.sync_off;
  assign fullstep_en         = st_ff.fs_en;
  assign stall_det_comm      = st_ff.det_comm;
  assign commutation_en      = st_ff.comm_en;
  assign min_velocity_active = st_ff.minv_act;
  // Minimum step velocity during commutation
  assign min_velocity        = {st_ff.comm_thr, COMM_PAD};
  assign position_wr         = st_ff.pos_wr;
  assign position_wr_data    = st_ff.pos_data;

endmodule : vtms_top

/* File: include/vtms_pkg.sv */
/*
  Constants, register map and compare helpers of the velocity threshold
  mode selector. Assumes a 50 MHz sys_clk and 32-bit register data.
*/
package vtms_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_PWM_THR  = 8'h00;
  localparam logic [7:0] ADDR_LOW_THR  = 8'h04;
  localparam logic [7:0] ADDR_HIGH_THR = 8'h08;
  localparam logic [7:0] ADDR_COMM_THR = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG   = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_INTERVAL = 8'h18;

  // Widths
  localparam int INTERVAL_W = 20;
  localparam int VEL_W      = 24;
  localparam int POS_W      = 32;
  localparam int COMM_HI    = 22;
  localparam int COMM_LO    = 8;
  localparam int COMM_KEEP  = 15;
  localparam int CFG_W      = 7;
  localparam int SUPP_W     = 12;

  // Values
  localparam logic [19:0]       INTERVAL_MAX = 20'hfffff;
  localparam logic [19:0]       THR_RESET    = 20'h00000;
  localparam logic [14:0]       COMM_RESET   = 15'h0000;
  localparam logic [23:0]       COMM_MIN     = 24'h000100;
  localparam logic [7:0]        COMM_PAD     = 8'h00;
  localparam logic [CFG_W-1:0]  CFG_RESET    = 7'h00;
  localparam logic [31:0]       POS_STEP     = 32'h00000001;
  localparam logic [31:0]       RD_ZERO      = 32'h00000000;

  // Stall blanking: 3 electrical periods of 1024 microsteps
  localparam logic [SUPP_W-1:0] SUPP_COUNT = 12'hc00;
  localparam logic [SUPP_W-1:0] SUPP_ZERO  = 12'h000;
  localparam logic [SUPP_W-1:0] SUPP_ONE   = 12'h001;

  // Configuration bit positions
  localparam int CFG_PWM       = 0;
  localparam int CFG_COOL      = 1;
  localparam int CFG_STOP      = 2;
  localparam int CFG_STALL_OUT = 3;
  localparam int CFG_HIGH_CHM  = 4;
  localparam int CFG_HIGH_FS   = 5;
  localparam int CFG_SMALL_HYS = 6;

  // Hysteresis shifts
  localparam int HYS_BIG   = 4;
  localparam int HYS_SMALL = 5;

  // Second compare value: thr*15/16-1 or thr*31/32-1, floored at zero
  function automatic logic [19:0] vtms_hys_lower(input logic [19:0] thr,
                                                  input logic        tight);
    logic [19:0] diff;
    diff = tight ? (thr - (thr >> HYS_SMALL)) : (thr - (thr >> HYS_BIG));
    return (diff == THR_RESET) ? THR_RESET : diff - 20'h00001;
  endfunction : vtms_hys_lower

  // Interval at or below threshold, with hysteresis on entry
  function automatic logic vtms_fast_next(input logic        cur,
                                          input logic [19:0] ival,
                                          input logic [19:0] thr,
                                          input logic        tight);
    return cur ? (ival <= thr) : (ival <= vtms_hys_lower(thr, tight));
  endfunction : vtms_fast_next

endpackage : vtms_pkg

/* File: include/vtms_meas_if.sv */
/*
  Carrier between the mode selector core and its interval measurement.
  Assumes both ends run on the same sys_clk.
*/
`timescale 1ns/100ps
interface vtms_meas_if;
  logic        step_evt;   // One 1/256 microstep
  logic        small_hys;  // Use 1/32 hysteresis
  logic [19:0] thr_pwm;    // Voltage PWM threshold
  logic [19:0] thr_low;    // Low velocity threshold
  logic [19:0] thr_high;   // High velocity threshold
  logic [19:0] interval;   // Measured step interval
  logic        fast_pwm;   // Interval at or below PWM threshold
  logic        fast_low;   // Interval at or below low threshold
  logic        fast_high;  // Interval at or below high threshold

  modport meas (input step_evt, small_hys, thr_pwm, thr_low, thr_high,
                output interval, fast_pwm, fast_low, fast_high);
  modport core (output step_evt, small_hys, thr_pwm, thr_low, thr_high,
                input interval, fast_pwm, fast_low, fast_high);
endinterface : vtms_meas_if

/* File: verilog/vtms_interval.sv */
/*
  Step interval measurement and the three hysteresis comparators.
  Assumes step_evt is a one-cycle pulse synchronous to sys_clk.
*/
`timescale 1ns/100ps
module vtms_interval
  import vtms_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset,
  vtms_meas_if.meas mif
);

  // Whole state of the measurement
  typedef struct packed {
    logic [19:0] count;     // Clocks since last microstep
    logic [19:0] interval;  // Last measured interval
    logic        fast_pwm;  // Compare states
    logic        fast_low;
    logic        fast_high;
  } vtms_meas_t;

  vtms_meas_t st_ff;   // Registered state
  vtms_meas_t nxt_st;  // Next state

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st = st_ff;
    // Count clocks, stop at all ones
    if (st_ff.count != INTERVAL_MAX) begin
      nxt_st.count = st_ff.count + 20'h00001;
    end
    if (mif.step_evt) begin
      // Clocks between two microsteps, saturated
      nxt_st.interval = nxt_st.count;
      nxt_st.count    = THR_RESET;
    end else if (st_ff.count == INTERVAL_MAX) begin
      // Standstill reads as all ones
      nxt_st.interval = INTERVAL_MAX;
    end
    // Every comparison re-evaluated each cycle
    nxt_st.fast_pwm  = vtms_fast_next(st_ff.fast_pwm, st_ff.interval,
                                      mif.thr_pwm, mif.small_hys);
    nxt_st.fast_low  = vtms_fast_next(st_ff.fast_low, st_ff.interval,
                                      mif.thr_low, mif.small_hys);
    nxt_st.fast_high = vtms_fast_next(st_ff.fast_high, st_ff.interval,
                                      mif.thr_high, mif.small_hys);
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_ff <= '{count: THR_RESET, interval: INTERVAL_MAX,
                 fast_pwm: 1'b0, fast_low: 1'b0, fast_high: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flops
  assign mif.interval  = st_ff.interval;
  assign mif.fast_pwm  = st_ff.fast_pwm;
  assign mif.fast_low  = st_ff.fast_low;
  assign mif.fast_high = st_ff.fast_high;

endmodule : vtms_interval

/* File: bench/vtms_props.sv */
/*
  Checker of the mode selector outputs, bound to vtms_top.
  Assumes one sys_clk domain and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module vtms_props
  import vtms_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        ramp_mode,
  input wire logic        commutation_enable_input,
  input wire logic        comm_step,
  input wire logic        comm_dir,
  input wire logic [31:0] actual_position,
  input wire logic        voltage_pwm_en,
  input wire logic        coolscale_en,
  input wire logic        stall_stop_en,
  input wire logic        stall_out_en,
  input wire logic        stall_suppress,
  input wire logic        chopper_mode_force,
  input wire logic        sync_off,
  input wire logic        fullstep_en,
  input wire logic        stall_det_comm,
  input wire logic        commutation_en,
  input wire logic        min_velocity_active,
  input wire logic [22:0] min_velocity,
  input wire logic        position_wr,
  input wire logic [31:0] position_wr_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////////
  // Register port and mode relations
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == RD_ZERO)
    else $error("read data outside read slot");
  a_pwm_cool_excl: assert property (voltage_pwm_en |-> !coolscale_en)
    else $error("pwm and current scaling both on");
  a_high_sync: assert property ((chopper_mode_force || fullstep_en) |-> sync_off)
    else $error("high band override without sync off");
  a_high_pwm_off: assert property (sync_off |-> !voltage_pwm_en && !coolscale_en)
    else $error("pwm or scaling on in high band");
  a_stall_blank: assert property (stall_suppress |-> !stall_stop_en && !stall_out_en)
    else $error("stall enable during blanking");
  a_stop_ramp: assert property (stall_stop_en |-> $past(ramp_mode))
    else $error("stall stop without ramp source");
  a_fullstep_det: assert property (fullstep_en |-> stall_det_comm)
    else $error("fullstep without comm stall detector");
  a_stepdir_comm: assert property (!$past(ramp_mode) && !$past(commutation_enable_input)
    |-> !commutation_en)
    else $error("step/dir commutation without request");
  a_comm_zero: assert property ((min_velocity == 23'h000000)[*4] |-> !min_velocity_active)
    else $error("commutation with zero threshold");
  a_thr_low_bits: assert property ($changed(min_velocity) |-> $past(reg_wr) &&
    min_velocity == {$past(reg_wdata[COMM_HI:COMM_LO]), COMM_PAD})
    else $error("threshold low bits not zero");
  a_min_vel: assert property (min_velocity_active |-> commutation_en)
    else $error("minimum velocity without commutation");
  a_pos_back: assert property (position_wr |-> $past(comm_step) && position_wr_data ==
    ($past(comm_dir) ? $past(actual_position) - POS_STEP
                     : $past(actual_position) + POS_STEP))
    else $error("position write back wrong");

  // Main scenarios reached
  c_comm: cover property (min_velocity_active);
  c_blank_end: cover property ($fell(stall_suppress));
  c_pos_down: cover property (position_wr && $past(comm_dir));
endmodule : vtms_props

bind vtms_top vtms_props u_vtms_props (
  .sys_clk(sys_clk), .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
  .ramp_mode(ramp_mode), .commutation_enable_input(commutation_enable_input),
  .comm_step(comm_step), .comm_dir(comm_dir), .actual_position(actual_position),
  .voltage_pwm_en(voltage_pwm_en), .coolscale_en(coolscale_en),
  .stall_stop_en(stall_stop_en), .stall_out_en(stall_out_en),
  .stall_suppress(stall_suppress), .chopper_mode_force(chopper_mode_force),
  .sync_off(sync_off), .fullstep_en(fullstep_en), .stall_det_comm(stall_det_comm),
  .commutation_en(commutation_en), .min_velocity_active(min_velocity_active),
  .min_velocity(min_velocity), .position_wr(position_wr), .reg_wdata(reg_wdata),
  .position_wr_data(position_wr_data)
);

/* File: bench/vtms_partner.sv */
/*
  Step source and position holder on the far side of the selector.
  Assumes the same sys_clk and synchronous reset as the design.
*/
`timescale 1ns/100ps
module vtms_partner
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [15:0] period,            // Clocks per microstep, 0 = standstill
  input wire logic        position_wr,
  input wire logic [31:0] position_wr_data,
  output logic            step_pulse,
  output logic [31:0]     actual_position
);
  logic [15:0] cnt_ff;                       // Clocks since last step

  ////////////////////////////////////////////////////////////////////////////////
  // One step pulse every period clocks; stops dead at standstill
  always_ff @(posedge sys_clk) begin
    if (reset || period == 16'h0000) begin
      cnt_ff     <= 16'h0001;
      step_pulse <= 1'b0;
    end else if (cnt_ff >= period) begin
      cnt_ff     <= 16'h0001;
      step_pulse <= 1'b1;
    end else begin
      cnt_ff     <= cnt_ff + 16'h0001;
      step_pulse <= 1'b0;
    end
  end

  // Position starts at the wrap point and takes the write-back
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      actual_position <= 32'hffffffff;
    end else if (position_wr) begin
      actual_position <= position_wr_data;
    end
  end
endmodule : vtms_partner

/* File: bench/vtms_top_bench.sv */
/*
  Testbench of vtms_top: register tasks, band and commutation sequences.
  Assumes the partner model and the bound checker from bench/.
*/
`timescale 1ns/100ps
module vtms_top_bench
  import vtms_pkg::*;
;
  logic               sys_clk;
  logic               reset;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [31:0]        reg_rdata;
  logic               step_pulse;
  logic               ramp_mode;
  logic signed [23:0] actual_velocity;
  logic               commutation_enable_input;
  logic               comm_step;
  logic               comm_dir;
  logic [31:0]        actual_position;
  wire  [10:0]        mode;                  // pwm,cool,stop,out,supp,chm,sync,fs,det,comm,minv
  logic [22:0]        min_velocity;
  logic               position_wr;
  logic [31:0]        position_wr_data;
  logic [15:0]        period;                // Step period handed to the partner
  int                 n_mismatch;
  int                 n_checks;
  int                 i;
  logic [15:0] per_tab [6] = '{16'h003c, 16'h0096, 16'h0061, 16'h005d, 16'h0064, 16'h0065};
  logic [10:0] mode_tab [6] = '{11'h380, 11'h400, 11'h400, 11'h380, 11'h380, 11'h400};

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  vtms_top u_vtms_top (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .step_pulse(step_pulse),
    .ramp_mode(ramp_mode), .actual_velocity(actual_velocity),
    .commutation_enable_input(commutation_enable_input), .comm_step(comm_step),
    .comm_dir(comm_dir), .actual_position(actual_position), .voltage_pwm_en(mode[10]),
    .coolscale_en(mode[9]), .stall_stop_en(mode[8]), .stall_out_en(mode[7]),
    .stall_suppress(mode[6]), .chopper_mode_force(mode[5]), .sync_off(mode[4]),
    .fullstep_en(mode[3]), .stall_det_comm(mode[2]), .commutation_en(mode[1]),
    .min_velocity_active(mode[0]), .min_velocity(min_velocity),
    .position_wr(position_wr), .position_wr_data(position_wr_data));

  vtms_partner u_vtms_partner (
    .sys_clk(sys_clk), .reset(reset), .period(period), .position_wr(position_wr),
    .position_wr_data(position_wr_data), .step_pulse(step_pulse),
    .actual_position(actual_position));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus and stimulus tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cm(input logic [10:0] e);
    chk("mode", {21'h000000, e}, {21'h000000, mode});
  endtask : cm

  // One write cycle, then one idle cycle so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  // Read data taken in the one cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(posedge sys_clk);
    chk(n, e, reg_rdata);
  endtask : rd

  task automatic settle();
    repeat (4) @(posedge sys_clk);
  endtask : settle

  // New step period, held long enough for the bands to follow
  task automatic go(input logic [15:0] p);
    period <= p;
    repeat (6 * p + 10) @(posedge sys_clk);
  endtask : go

  task automatic cstep(input logic d, input logic [31:0] e);
    comm_dir  <= d;
    comm_step <= 1'b1;
    @(posedge sys_clk);
    comm_step <= 1'b0;
    @(posedge sys_clk);
    chk("position_wr", 32'h00000001, {31'h00000000, position_wr});
    chk("position_wr_data", e, position_wr_data);
    @(posedge sys_clk);
  endtask : cstep

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // Run needs about 40000 cycles; more means a hang
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ramp_mode = 1'b1;
    actual_velocity = 24'sh000000;
    commutation_enable_input = 1'b0;
    comm_step = 1'b0;
    comm_dir = 1'b0;
    period = 16'h0000;
    n_mismatch = 0;
    n_checks = 0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    cm(11'h000);
    rd(ADDR_INTERVAL, 32'h000fffff, "interval");
    rd(ADDR_LOW_THR, RD_ZERO, "low_thr");
    rd(8'h40, RD_ZERO, "unmapped");
    rd(ADDR_CONFIG, RD_ZERO, "config");
    wr(ADDR_CONFIG, 32'h0000003f);
    wr(ADDR_PWM_THR, 32'h000000c8);
    wr(ADDR_LOW_THR, 32'hfff00064);
    wr(ADDR_HIGH_THR, 32'h00000028);
    rd(ADDR_CONFIG, 32'h0000003f, "config");
    settle();
    cm(11'h400);
    for (i = 0; i < 6; i++) begin
      go(per_tab[i]);
      cm(mode_tab[i]);
    end
    rd(ADDR_INTERVAL, 32'h00000065, "interval");
    wr(ADDR_CONFIG, 32'h0000007f);
    go(16'h0060);
    cm(11'h380);
    go(16'h0096);
    wr(ADDR_COMM_THR, 32'h000001ff);
    actual_velocity <= 24'sh000200;
    settle();
    chk("min_velocity", 32'h00000100, {9'h000, min_velocity});
    cm(11'h07f);
    rd(ADDR_STATUS, 32'h00000038, "status");
    actual_velocity <= -24'sh000200;
    settle();
    cm(11'h07f);
    actual_velocity <= 24'sh0000ff;
    settle();
    cm(11'h440);
    wr(ADDR_COMM_THR, 32'h000000ff);
    actual_velocity <= 24'sh000200;
    settle();
    chk("min_velocity", RD_ZERO, {9'h000, min_velocity});
    cm(11'h440);
    ramp_mode <= 1'b0;
    wr(ADDR_COMM_THR, 32'h00000100);
    settle();
    cm(11'h440);
    commutation_enable_input <= 1'b1;
    settle();
    cm(11'h446);
    go(16'h00fa);
    cm(11'h440);
    go(16'h0096);
    cm(11'h446);
    cstep(1'b0, 32'h00000000);
    cstep(1'b1, 32'hffffffff);
    chk("actual_position", 32'hffffffff, actual_position);
    commutation_enable_input <= 1'b0;
    ramp_mode <= 1'b1;
    actual_velocity <= 24'sh000000;
    go(16'h000a);
    cm(11'h07c);
    repeat (29000) @(posedge sys_clk);
    cm(11'h07c);
    repeat (2500) @(posedge sys_clk);
    cm(11'h1bc);
    go(16'h003c);
    cm(11'h240);
    rd(ADDR_INTERVAL, 32'h0000003c, "interval");
    report_and_stop();
  end
endmodule : vtms_top_bench
